// file: design/paa_pkg.sv
// Package with the register map, field layout and timing of the aux inputs.
package paa_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timebase.
    localparam int MCLK_PERIOD_NS = 8;
    localparam int TICK_NS        = 1000000;
    localparam int TICK_CYCLES    = TICK_NS / MCLK_PERIOD_NS;

    // Times in milliseconds, counted on the millisecond tick.
    localparam int FLOAT_ON_MS    = 1000;
    localparam int FLOAT_OFF_MS   = 30000;
    localparam int AUX_ON_MS      = 1000;
    localparam int AUX_OFF_MS     = 1000;
    localparam int DIS_ON_MS      = 1000;
    localparam int DIS_OFF_MS     = 1000;
    localparam int LP_ON_MS       = 1000;
    localparam int LP_OFF_MS      = 2000;
    localparam int AB_PERIOD_MS   = 23 * 3600 * 1000;
    localparam int AB_RUN_MS      = 60 * 1000;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses).
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  CTRL_OFS     = 8'h00;
    localparam logic [7:0]  SELECT_OFS   = 8'h04;
    localparam logic [7:0]  STATUS_OFS   = 8'h08;
    localparam logic [7:0]  COMMAND_OFS  = 8'h0c;

    // Control fields.
    localparam int          CTRL_AB_BIT  = 0;
    localparam int          CTRL_AF_BIT  = 1;
    localparam logic [1:0]  CTRL_RESET   = 2'h0;
    // Select register: four 4-bit fields, input n at bits 4n+3..4n.
    localparam int          SEL_W        = 4;
    localparam logic [15:0] SELECT_RESET = 16'h0000;
    // Command field: manual reset of latched low-pressure blocks.
    localparam int          CMD_MRST_BIT = 0;

    // Status fields.
    localparam int ST_WATER_BIT  = 0;
    localparam int ST_MOTOR_BIT  = 1;
    localparam int ST_LOWP_BIT   = 2;
    localparam int ST_AUXI_BIT   = 3;
    localparam int ST_ROT_BIT    = 4;
    localparam int ST_BLOCK_BIT  = 5;
    localparam int ST_QUAL_LSB   = 8;
    localparam int ST_AUXM_LSB   = 12;

    ////////////////////////////////////////////////////////////////////////
    // Function kinds that a select code chooses.
    typedef enum {
        FN_NONE, FN_FLOAT, FN_AUX, FN_DIS, FN_DISRST, FN_RST,
        FN_LPAUTO, FN_LPMAN
    } paa_func_type;

endpackage : paa_pkg

// file: design/paa_aux_inputs.sv
// Aux input function logic, anti-block and anti-freeze rotation, APB slave.
//
// Function
// - Anti-block: one minute run every 23 hours.
// - Anti-freeze: rotate while temperature near freezing.
// - Four identical inputs, each own select.
// - Reset leaves every select at zero.
// - Select zero disables input whatever level.
// - Codes 1/2 float NO/NC, water alarm.
// - Codes 3/4 aux setpoint NO/NC, indicator.
// - Codes 5/6 motor disable NO/NC.
// - Codes 7/8 disable plus block reset.
// - Code 9 block reset only, no indication.
// - Codes 10/11 low pressure, auto+manual reset.
// - Codes 12/13 low pressure, manual reset only.
// - Float NO high present, NC low present.
// - Active float blocks system, shows symbol.
// - Float must hold one second before alarm.
// - Float alarm holds until thirty seconds inactive.
// - Any float input raises, none clears alarm.
// - Aux setpoint one second on and off.
// - Low pressure auto reset after two seconds.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps

module paa_aux_inputs
    import paa_pkg::*;
#(
    parameter int TICK_CYC = paa_pkg::TICK_CYCLES,
    parameter int FL_ON    = paa_pkg::FLOAT_ON_MS,
    parameter int FL_OFF   = paa_pkg::FLOAT_OFF_MS,
    parameter int AX_ON    = paa_pkg::AUX_ON_MS,
    parameter int AX_OFF   = paa_pkg::AUX_OFF_MS,
    parameter int DS_ON    = paa_pkg::DIS_ON_MS,
    parameter int DS_OFF   = paa_pkg::DIS_OFF_MS,
    parameter int LP_ON    = paa_pkg::LP_ON_MS,
    parameter int LP_OFF   = paa_pkg::LP_OFF_MS,
    parameter int AB_PER   = paa_pkg::AB_PERIOD_MS,
    parameter int AB_RUN   = paa_pkg::AB_RUN_MS
) (
    // Clock and reset.
    input  wire logic                       MCLK,
    input  wire logic                       RST,
    // APB slave.
    input  wire logic                       PSEL,
    input  wire logic                       PENABLE,
    input  wire logic                       PWRITE,
    input  wire logic [paa_pkg::ADDR_W-1:0] PADDR,
    input  wire logic [31:0]                PWDATA,
    output logic      [31:0]                PRDATA,
    output logic                            PREADY,
    output logic                            PSLVERR,
    // Inputs from the wireless control unit and the temperature sense.
    input  wire logic [3:0]                 AUX_INPUT,
    input  wire logic                       NEAR_FREEZE,
    // Indications and pump commands.
    output logic                            WATER_LACK_ALARM,
    output logic                            MOTOR_DISABLE_ALARM,
    output logic                            LOW_PRESSURE_ALARM,
    output logic                            AUX_SETPOINT_INDICATOR,
    output logic      [3:0]                 AUX_SETPOINT_ACTIVE,
    output logic                            SYSTEM_BLOCK,
    output logic                            BLOCK_RESET,
    output logic                            PUMP_ROTATE
);
    import paa_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State.
    typedef struct packed {
        logic [1:0]       ctrl;
        logic [15:0]      sel;
        logic [3:0]       qual;
        logic [3:0][15:0] cnt;
        logic [3:0]       raw_prev;
        logic [16:0]      tick_cnt;
        logic             tick;
        logic [26:0]      ab_cnt;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
        logic             water;
        logic             motor;
        logic             lowp;
        logic             auxi;
        logic [3:0]       auxm;
        logic             block;
        logic             blk_rst;
        logic             rotate;
    } paa_state_type;

    paa_state_type s_r;
    paa_state_type s_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Select code decoding.
    function automatic paa_func_type fn_kind(input logic [3:0] code);
        case (code)
            4'h1, 4'h2: fn_kind = FN_FLOAT;
            4'h3, 4'h4: fn_kind = FN_AUX;
            4'h5, 4'h6: fn_kind = FN_DIS;
            4'h7, 4'h8: fn_kind = FN_DISRST;
            4'h9:       fn_kind = FN_RST;
            4'ha, 4'hb: fn_kind = FN_LPAUTO;
            4'hc, 4'hd: fn_kind = FN_LPMAN;
            default:    fn_kind = FN_NONE;
        endcase
    endfunction : fn_kind

    // Normally-closed codes take a low input as present.
    function automatic logic fn_nc(input logic [3:0] code);
        case (code)
            4'h2, 4'h4, 4'h6, 4'h8, 4'hb, 4'hd: fn_nc = 1'b1;
            default:                            fn_nc = 1'b0;
        endcase
    endfunction : fn_nc

    function automatic logic [15:0] on_ms(input paa_func_type k);
        case (k)
            FN_FLOAT:            on_ms = 16'(FL_ON);
            FN_AUX:              on_ms = 16'(AX_ON);
            FN_LPAUTO, FN_LPMAN: on_ms = 16'(LP_ON);
            default:             on_ms = 16'(DS_ON);
        endcase
    endfunction : on_ms

    function automatic logic [15:0] off_ms(input paa_func_type k);
        case (k)
            FN_FLOAT:            off_ms = 16'(FL_OFF);
            FN_AUX:              off_ms = 16'(AX_OFF);
            FN_LPAUTO, FN_LPMAN: off_ms = 16'(LP_OFF);
            default:             off_ms = 16'(DS_OFF);
        endcase
    endfunction : off_ms

    ////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        paa_func_type kind;
        logic [3:0]   code;
        logic         raw;
        logic [15:0]  target;
        logic         setup;
        logic         access;
        logic         mapped;
        logic         mrst;
        logic         rst_any;
        logic         float_any;
        logic         dis_any;
        logic         lp_any;
        logic [3:0]   aux_q;

        kind      = FN_NONE;
        code      = 4'h0;
        raw       = 1'b0;
        target    = 16'h0000;
        rst_any   = 1'b0;
        float_any = 1'b0;
        dis_any   = 1'b0;
        lp_any    = 1'b0;
        aux_q     = 4'h0;
        setup     = 1'b0;
        access    = 1'b0;
        mapped    = 1'b0;
        mrst      = 1'b0;
        s_nxt     = s_r;

        // APB slave: setup cycle prepares the answer, access completes it.
        setup  = PSEL && !PENABLE;
        access = PSEL && PENABLE && s_r.pready;
        mapped = (PADDR == CTRL_OFS) || (PADDR == SELECT_OFS) ||
                 (PADDR == STATUS_OFS) || (PADDR == COMMAND_OFS);
        s_nxt.pready  = setup;
        s_nxt.pslverr = setup && !mapped;
        s_nxt.prdata  = 32'h0000_0000;
        if (setup && !PWRITE) begin
            case (PADDR)
                CTRL_OFS:   s_nxt.prdata = {30'h0, s_r.ctrl};
                SELECT_OFS: s_nxt.prdata = {16'h0, s_r.sel};
                STATUS_OFS: begin
                    s_nxt.prdata[ST_WATER_BIT] = s_r.water;
                    s_nxt.prdata[ST_MOTOR_BIT] = s_r.motor;
                    s_nxt.prdata[ST_LOWP_BIT]  = s_r.lowp;
                    s_nxt.prdata[ST_AUXI_BIT]  = s_r.auxi;
                    s_nxt.prdata[ST_ROT_BIT]   = s_r.rotate;
                    s_nxt.prdata[ST_BLOCK_BIT] = s_r.block;
                    s_nxt.prdata[ST_QUAL_LSB +: 4] = s_r.qual;
                    s_nxt.prdata[ST_AUXM_LSB +: 4] = s_r.auxm;
                end
                default:    s_nxt.prdata = 32'h0000_0000;
            endcase
        end
        mrst = access && PWRITE && (PADDR == COMMAND_OFS) &&
               PWDATA[CMD_MRST_BIT];
        if (access && PWRITE) begin
            if (PADDR == CTRL_OFS) begin
                s_nxt.ctrl = PWDATA[1:0];
            end
            if (PADDR == SELECT_OFS) begin
                s_nxt.sel = PWDATA[15:0];
            end
        end

        // Millisecond tick.
        s_nxt.tick = 1'b0;
        if (s_r.tick_cnt == 17'(TICK_CYC - 1)) begin
            s_nxt.tick_cnt = 17'h0;
            s_nxt.tick     = 1'b1;
        end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + 17'h1;
        end

        // Block reset pulses from functions 7, 8 and 9.
        for (int i = 0; i < 4; i++) begin
            code = s_r.sel[i*SEL_W +: SEL_W];
            kind = fn_kind(code);
            raw  = (AUX_INPUT[i] ^ fn_nc(code)) &&
                   (kind != FN_NONE);
            s_nxt.raw_prev[i] = raw;
            if ((kind == FN_DISRST || kind == FN_RST) && raw &&
                !s_r.raw_prev[i]) begin
                rst_any = 1'b1;
            end
        end

        // Per-input qualification, identical for all four inputs.
        for (int i = 0; i < 4; i++) begin
            code   = s_r.sel[i*SEL_W +: SEL_W];
            kind   = fn_kind(code);
            raw    = (AUX_INPUT[i] ^ fn_nc(code)) && (kind != FN_NONE);
            target = s_r.qual[i] ? off_ms(kind) : on_ms(kind);
            if (kind == FN_NONE || kind == FN_RST) begin
                s_nxt.qual[i] = 1'b0;
                s_nxt.cnt[i]  = 16'h0;
            end else if (raw == s_r.qual[i]) begin
                s_nxt.cnt[i] = 16'h0;
            end else if (kind == FN_LPMAN && s_r.qual[i]) begin
                // Only a manual or block reset releases this latch.
                s_nxt.cnt[i] = 16'h0;
                if (mrst || rst_any) begin
                    s_nxt.qual[i] = 1'b0;
                end
            end else if (kind == FN_LPAUTO && s_r.qual[i] &&
                         (mrst || rst_any)) begin
                s_nxt.qual[i] = 1'b0;
                s_nxt.cnt[i]  = 16'h0;
            end else if (s_r.tick) begin
                if (s_r.cnt[i] + 16'h1 >= target) begin
                    s_nxt.qual[i] = raw;
                    s_nxt.cnt[i]  = 16'h0;
                end else begin
                    s_nxt.cnt[i] = s_r.cnt[i] + 16'h1;
                end
            end
            case (kind)
                FN_FLOAT:            float_any = float_any | s_nxt.qual[i];
                FN_AUX:              aux_q[i]  = s_nxt.qual[i];
                FN_DIS, FN_DISRST:   dis_any   = dis_any | s_nxt.qual[i];
                FN_LPAUTO, FN_LPMAN: lp_any    = lp_any | s_nxt.qual[i];
                default:             ;
            endcase
        end

        s_nxt.water   = float_any;
        s_nxt.motor   = dis_any;
        s_nxt.lowp    = lp_any;
        s_nxt.auxm    = aux_q;
        s_nxt.auxi    = |aux_q;
        s_nxt.block   = float_any | dis_any | lp_any;
        s_nxt.blk_rst = rst_any;

        // Anti-block: the last minute of each 23-hour period is a run.
        if (!s_r.ctrl[CTRL_AB_BIT]) begin
            s_nxt.ab_cnt = 27'h0;
        end else if (s_r.tick) begin
            if (s_r.ab_cnt == 27'(AB_PER - 1)) begin
                s_nxt.ab_cnt = 27'h0;
            end else begin
                s_nxt.ab_cnt = s_r.ab_cnt + 27'h1;
            end
        end
        s_nxt.rotate = (s_r.ctrl[CTRL_AB_BIT] &&
                        s_r.ab_cnt >= 27'(AB_PER - AB_RUN)) ||
                       (s_r.ctrl[CTRL_AF_BIT] && NEAR_FREEZE);
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            s_r      <= '0;
            s_r.ctrl <= CTRL_RESET;
            s_r.sel  <= SELECT_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign PRDATA                 = s_r.prdata;
    assign PREADY                 = s_r.pready;
    assign PSLVERR                = s_r.pslverr;
    assign WATER_LACK_ALARM       = s_r.water;
    assign MOTOR_DISABLE_ALARM    = s_r.motor;
    assign LOW_PRESSURE_ALARM     = s_r.lowp;
    assign AUX_SETPOINT_INDICATOR = s_r.auxi;
    assign AUX_SETPOINT_ACTIVE    = s_r.auxm;
    assign SYSTEM_BLOCK           = s_r.block;
    assign BLOCK_RESET            = s_r.blk_rst;
    assign PUMP_ROTATE            = s_r.rotate;

endmodule : paa_aux_inputs

// file: bench/paa_wcu_model.sv
// Model of the wireless control unit that reports four input levels.
`timescale 1ns/1ps
module paa_wcu_model (
    // Clock.
    input  wire logic       mclk,
    // Levels commanded by the bench.
    input  wire logic [3:0] lvl,
    // Input states sent to the pump.
    output logic      [3:0] aux_input
);
    // The unit reports each level one cycle after the bench commands it.
    always_ff @(posedge mclk) begin
        aux_input <= lvl;
    end
endmodule : paa_wcu_model

// file: bench/paa_aux_inputs_props.sv
// Checker of the aux input block, bound to its ports.
`timescale 1ns/1ps
module paa_aux_props (
    // Clock, reset and APB.
    input wire logic        MCLK,
    input wire logic        RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // Temperature sense, indications and commands.
    input wire logic        NEAR_FREEZE,
    input wire logic        WATER_LACK_ALARM,
    input wire logic        MOTOR_DISABLE_ALARM,
    input wire logic        LOW_PRESSURE_ALARM,
    input wire logic        AUX_SETPOINT_INDICATOR,
    input wire logic [3:0]  AUX_SETPOINT_ACTIVE,
    input wire logic        SYSTEM_BLOCK,
    input wire logic        BLOCK_RESET,
    input wire logic        PUMP_ROTATE
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    chk_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready after setup");
    chk_ready_only_access: assert property (PREADY |-> $past(PSEL && !PENABLE))
        else $error("ready without setup");
    chk_rdata_idle_zero: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside access");
    chk_slverr_with_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    chk_block_any_alarm: assert property (
        SYSTEM_BLOCK == (WATER_LACK_ALARM || MOTOR_DISABLE_ALARM ||
        LOW_PRESSURE_ALARM))
        else $error("block differs from alarms");
    chk_aux_ind_mask: assert property (
        AUX_SETPOINT_INDICATOR == (|AUX_SETPOINT_ACTIVE))
        else $error("indicator differs from mask");
    chk_reset_one_pulse: assert property (
        BLOCK_RESET |=> !BLOCK_RESET)
        else $error("block reset longer than one cycle");
    chk_water_hold_min: assert property (
        $rose(WATER_LACK_ALARM) |-> WATER_LACK_ALARM [*8])
        else $error("water alarm dropped early");
    chk_rot_run_len: assert property (
        $rose(PUMP_ROTATE) && !NEAR_FREEZE |-> PUMP_ROTATE [*8])
        else $error("anti-block run too short");
endmodule : paa_aux_props
bind paa_aux_inputs paa_aux_props i_paa_aux_props (.MCLK(MCLK), .RST(RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .NEAR_FREEZE(NEAR_FREEZE),
    .WATER_LACK_ALARM(WATER_LACK_ALARM),
    .MOTOR_DISABLE_ALARM(MOTOR_DISABLE_ALARM),
    .LOW_PRESSURE_ALARM(LOW_PRESSURE_ALARM),
    .AUX_SETPOINT_INDICATOR(AUX_SETPOINT_INDICATOR),
    .AUX_SETPOINT_ACTIVE(AUX_SETPOINT_ACTIVE), .SYSTEM_BLOCK(SYSTEM_BLOCK),
    .BLOCK_RESET(BLOCK_RESET), .PUMP_ROTATE(PUMP_ROTATE));

// file: bench/tb_top.sv
// Testbench of the aux input block, driven over APB.
`timescale 1ns/1ps
module tb_top;
    import paa_pkg::*;
    localparam int TK    = 4;
    localparam int QON   = 3;
    localparam int FLOFF = 10;
    localparam int ABP   = 50;
    localparam int ABR   = 5;
    logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic freeze = 1'b0;
    logic [7:0] padr = 8'h00;
    logic [31:0] pwd = 32'h0, prdata, rdat, e;
    logic [3:0] lvl = 4'h0, aux, mask;
    logic pready, pslverr, water, motor, lowp, auxi, blk, brst, rot, rerr;
    int n_mismatch = 0, compares = 0, n_brst = 0, b0, n;
    always #4 mclk = ~mclk;
    always @(posedge mclk) if (brst === 1'b1) n_brst <= n_brst + 1;
    paa_wcu_model i_paa_wcu_model (.mclk(mclk), .lvl(lvl), .aux_input(aux));
    paa_aux_inputs #(.TICK_CYC(TK), .FL_ON(QON), .FL_OFF(FLOFF),
        .AX_ON(QON), .AX_OFF(QON), .DS_ON(QON), .DS_OFF(QON), .LP_ON(QON),
        .LP_OFF(QON), .AB_PER(ABP), .AB_RUN(ABR)) i_paa_aux_inputs (
        .MCLK(mclk), .RST(rst),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .AUX_INPUT(aux),
        .NEAR_FREEZE(freeze), .WATER_LACK_ALARM(water),
        .MOTOR_DISABLE_ALARM(motor), .LOW_PRESSURE_ALARM(lowp),
        .AUX_SETPOINT_INDICATOR(auxi), .AUX_SETPOINT_ACTIVE(mask),
        .SYSTEM_BLOCK(blk), .BLOCK_RESET(brst), .PUMP_ROTATE(rot));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wcyc(input int c);
        repeat (c) @(posedge mclk);
    endtask : wcyc
    // One APB transfer; holds the request until ready is sampled high.
    // The bus then idles one cycle, so no signal is driven twice at once.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pen  <= 1'b0;
        pwr  <= w;
        padr <= a;
        pwd  <= d;
        @(posedge mclk);
        pen <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge mclk);
    endtask : apb
    function automatic logic is_nc(input int c);
        return c == 2 || c == 4 || c == 6 || c == 8 || c == 11 || c == 13;
    endfunction : is_nc
    // Expected status with the per-input qualified field masked out.
    function automatic logic [31:0] exp_st(input int c, input logic act);
        logic m, l, x;
        m = act && c >= 5 && c <= 8;
        l = c >= 12 || (act && c >= 10);
        x = act && (c == 3 || c == 4);
        return {16'h0, x ? 4'h2 : 4'h0, 6'h0, m || l, 1'b0, x, l, m, 1'b0};
    endfunction : exp_st
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        wcyc(3);
        rst <= 1'b0;
        apb(1'b0, SELECT_OFS, 32'h0);
        chk("select reset", rdat, 32'h0);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl reset", rdat, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped err", rerr, 32'h1);
        chk("unmapped data", rdat, 32'h0);
        apb(1'b1, SELECT_OFS, 32'hffff_dcba);
        apb(1'b0, SELECT_OFS, 32'h0);
        chk("select rw", rdat, 32'h0000_dcba);
        apb(1'b1, SELECT_OFS, 32'h0);
        lvl <= 4'hf;
        wcyc(30);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("disabled", rdat & 32'hf0ff, 32'h0);
        lvl <= 4'h0;
        apb(1'b1, SELECT_OFS, 32'h0011);
        lvl <= 4'h1;
        wcyc(6);
        lvl <= 4'h0;
        wcyc(2);
        lvl <= 4'h1;
        wcyc(6);
        lvl <= 4'h0;
        wcyc(30);
        chk("float glitch", water, 1'b0);
        lvl <= 4'h3;
        wcyc(24);
        chk("float on", water, 1'b1);
        chk("float block", blk, 1'b1);
        lvl <= 4'h2;
        wcyc(60);
        chk("float any", water, 1'b1);
        lvl <= 4'h0;
        wcyc(28);
        chk("float hold", water, 1'b1);
        wcyc(30);
        chk("float off", water, 1'b0);
        lvl <= 4'h1;
        apb(1'b1, SELECT_OFS, 32'h0002);
        wcyc(40);
        chk("nc idle", water, 1'b0);
        lvl <= 4'h0;
        wcyc(24);
        chk("nc on", water, 1'b1);
        lvl <= 4'h1;
        wcyc(60);
        chk("nc off", water, 1'b0);
        apb(1'b1, SELECT_OFS, 32'h0);
        for (int c = 3; c <= 13; c++) begin
            lvl <= {2'b00, is_nc(c), 1'b0};
            b0 = n_brst;
            apb(1'b1, SELECT_OFS, c << 4);
            lvl <= {2'b00, !is_nc(c), 1'b0};
            wcyc(30);
            e = exp_st(c, 1'b1);
            apb(1'b0, STATUS_OFS, 32'h0);
            chk("code on", rdat & 32'hfffff0ff, e);
            chk("aux mask", mask, e >> 12);
            chk("aux ind pin", auxi, e[3]);
            chk("motor pin", motor, e[1]);
            chk("lowp pin", lowp, e[2]);
            chk("pulse", n_brst > b0, c inside {[7:9]});
            lvl <= {2'b00, is_nc(c), 1'b0};
            wcyc(30);
            e = exp_st(c, 1'b0);
            apb(1'b0, STATUS_OFS, 32'h0);
            chk("code off", rdat & 32'hfffff0ff, e);
            chk("lowp latch", lowp, e[2]);
            apb(1'b1, COMMAND_OFS, 32'h1);
            wcyc(4);
            chk("manual clear", lowp, 1'b0);
            apb(1'b1, SELECT_OFS, 32'h0);
        end
        lvl <= 4'h0;
        apb(1'b1, CTRL_OFS, 32'h1);
        n = 0;
        while (rot !== 1'b1 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        n = 0;
        while (rot === 1'b1 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        chk("run length", n, ABR * TK);
        apb(1'b1, CTRL_OFS, 32'h0);
        freeze <= 1'b1;
        wcyc(8);
        chk("freeze off", rot, 1'b0);
        apb(1'b1, CTRL_OFS, 32'h2);
        wcyc(4);
        chk("freeze on", rot, 1'b1);
        freeze <= 1'b0;
        wcyc(4);
        chk("freeze end", rot, 1'b0);
        tally_and_finish();
    end
endmodule : tb_top
